/* File: src/bfe_pkg.sv */
// Constants, carriers and modes of the Bayer front end pipeline.
// Assumes one 50 MHz core clock; pixel stream arrives on that clock.
package bfe_pkg;
  localparam int         PIX_W     = 10;
  localparam logic [9:0] PIX_MAX   = 10'h3ff;
  localparam int         LINE_W    = 1600;
  localparam int         LB_ROWS   = 8;
  localparam int         WIN       = 5;
  localparam int         GAIN_FRAC = 5;
  localparam logic [7:0] GAIN_ONE  = 8'h20;
  localparam int         SHD_FRAC  = 10;
  localparam int         SHD_KSH   = 20;
  localparam logic [11:0] SHD_ONE  = 12'h400;

  typedef enum logic [1:0] {TP_FLAT, TP_HRAMP, TP_VRAMP, TP_CHECK} bfe_tp_t;
  typedef enum logic [1:0] {BFE_R, BFE_GR, BFE_GB, BFE_B} bfe_col_t;

  typedef struct packed {
    logic       vld;
    logic       sof;
    logic       sol;
    logic [9:0] data;
  } bfe_raw_t;

  typedef struct packed {
    logic        vld;
    logic        sof;
    logic        sol;
    logic [10:0] col;
    logic [10:0] row;
    logic [9:0]  pix;
  } bfe_stg_t;

  typedef struct packed {
    logic       sof;
    logic       sol;
    logic       rp;
    logic       cp;
    logic [9:0] pix;
  } bfe_word_t;

  // Shading coefficient index: [channel R/G/B][dir x/y][piece below/above]
  typedef struct packed {
    logic                      tp_en;
    bfe_tp_t                   tp_sel;
    logic [9:0]                tp_level;
    logic [9:0]                black;
    logic [7:0]                gain;
    logic [1:0]                bayer;
    logic [10:0]               ctr_x;
    logic [10:0]               ctr_y;
    logic [2:0][1:0][1:0][7:0] shd_k;
    logic                      dpc_en;
    logic [9:0]                dpc_thr;
    logic [9:0]                edge_thr;
  } bfe_cfg_t;

  typedef struct packed {
    logic       vld;
    logic       sof;
    logic       sol;
    logic [9:0] r;
    logic [9:0] g;
    logic [9:0] b;
  } bfe_rgb_t;
endpackage

/* File: src/bfe_pipe.sv */
// Bayer front end: test pattern, black level, gain, shading, line
// buffers, defect masking and edge-sensitive interpolation to RGB.
// Assumes stream and config on i_core_clk; config held quasi-static.
`timescale 1ns/1ps
// Overview of operation
// R1 - Input pixels are single 10-bit samples of one Bayer colour.
// R2 - Stream is processed continuously, no pause between frames.
// R3 - Test mode replaces sensor data with a selectable generated pattern.
// R4 - Black level subtraction is the first processing step.
// R5 - Every pixel is multiplied by one programmable digital gain.
// R6 - Shading multiplies each colour by a column and row function.
// R7 - Shading profile piecewise quadratic, coefficients per direction and colour.
// R8 - Line buffers give later stages up to 8 lines at once.
// R9 - Defect test flags hot, too dark or too bright pixels on the fly.
// R10 - Defective pixels are replaced by the average of the four same-colour pixels two steps away in row and column.
// R11 - One sample per pixel is kept up to defect correction.
// R12 - Interpolation outputs a full RGB triple for each pixel.
// R13 - Edges are detected and neighbour selection follows the result.
// R14 - Flat areas are averaged, edges are not smoothed across. Only green is steered; red and blue averages span edges.
// R15 - Each output colour component is 10 bits wide.
// R16 - Line and frame markers travel aligned with the pixel data.
// R17 - Black, gain and shading results clamp to the 10-bit range.
module bfe_pipe import bfe_pkg::*; (
  input  wire logic     i_core_clk,
  input  wire logic     i_arst_n,
  input  wire logic     i_ce,
  input  wire bfe_raw_t i_pix,
  input  wire bfe_cfg_t i_cfg,
  output bfe_rgb_t      o_rgb
);
  logic [10:0] col_q, row_q, col_d, row_d;
  logic [9:0]  tp_val;
  bfe_stg_t    s0_q, s1_q, s2_q;

  always_comb begin
    col_d = i_pix.sol ? '0 : col_q + 11'h1;
    row_d = i_pix.sof ? '0 : (i_pix.sol ? row_q + 11'h1 : row_q);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      col_q <= '0;
      row_q <= '0;
    end else if (i_ce && i_pix.vld) begin
      col_q <= col_d;
      row_q <= row_d;
    end
  end

  always_comb begin
    case (i_cfg.tp_sel)
      TP_FLAT:  tp_val = i_cfg.tp_level;
      TP_HRAMP: tp_val = col_d[9:0];
      TP_VRAMP: tp_val = row_d[9:0];
      default:  tp_val = {10{col_d[4] ^ row_d[4]}};
    endcase
  end

  // Input stage; sensor timing keeps running under test pattern
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s0_q <= '0;
    end else if (i_ce) begin
      s0_q <= {i_pix.vld, i_pix.sof, i_pix.sol, col_d, row_d,
               i_cfg.tp_en ? tp_val : i_pix.data}; // [R1] [R2] [R3]
    end
  end

  logic [10:0] bdif;
  logic [9:0]  blk;
  logic [17:0] gprod;
  logic [12:0] gsh;
  always_comb begin
    bdif  = {1'b0, s0_q.pix} - {1'b0, i_cfg.black};
    blk   = bdif[10] ? '0 : bdif[9:0]; // [R4] [R17]
    gprod = {8'h0, blk} * {10'h0, i_cfg.gain}; // [R5]
    gsh   = gprod[17:GAIN_FRAC];
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
    end else if (i_ce) begin
      s1_q     <= s0_q;
      s1_q.pix <= |gsh[12:10] ? PIX_MAX : gsh[9:0]; // [R17]
    end
  end

  function automatic logic [11:0] shd_f(input logic [10:0] pos, input logic [10:0] ctr,
                                        input logic [7:0] kn, input logic [7:0] kp);
    logic [10:0] d;
    logic [31:0] q;
    d = (pos >= ctr) ? pos - ctr : ctr - pos;
    q = {21'h0, d} * {21'h0, d};
    q = q * {24'h0, (pos >= ctr) ? kp : kn};
    q = q >> SHD_KSH;
    return SHD_ONE + q[11:0]; // [R7]
  endfunction

  bfe_col_t    scol;
  logic [1:0]  chn;
  logic [11:0] fx, fy, ff, ss;
  logic [23:0] fxy;
  logic [21:0] sp;
  always_comb begin
    scol = bfe_col_t'({s1_q.row[0], s1_q.col[0]} ^ i_cfg.bayer);
    chn  = (scol == BFE_R) ? 2'd0 : ((scol == BFE_B) ? 2'd2 : 2'd1);
    fx   = shd_f(s1_q.col, i_cfg.ctr_x, i_cfg.shd_k[chn][0][0], i_cfg.shd_k[chn][0][1]);
    fy   = shd_f(s1_q.row, i_cfg.ctr_y, i_cfg.shd_k[chn][1][0], i_cfg.shd_k[chn][1][1]);
    fxy  = {12'h0, fx} * {12'h0, fy};
    ff   = fxy[21:SHD_FRAC];
    sp   = {12'h0, s1_q.pix} * {10'h0, ff}; // [R6]
    ss   = sp[21:SHD_FRAC];
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s2_q <= '0;
    end else if (i_ce) begin
      s2_q     <= s1_q;
      s2_q.pix <= |ss[11:10] ? PIX_MAX : ss[9:0]; // [R17] [R11]
    end
  end

  // Line memories: tap[LB_ROWS-1] is the live line, tap[0] the oldest
  bfe_word_t mem [LB_ROWS-1][LINE_W];
  bfe_word_t tap [LB_ROWS];
  always_comb begin
    tap[LB_ROWS-1] = {s2_q.sof, s2_q.sol, s2_q.row[0], s2_q.col[0], s2_q.pix}; // [R16]
    for (int r = 0; r < LB_ROWS - 1; r++) begin
      tap[r] = mem[r][s2_q.col];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_ce && s2_q.vld) begin
      for (int r = 0; r < LB_ROWS - 1; r++) begin
        mem[r][s2_q.col] <= tap[r+1]; // [R8]
      end
    end
  end

  bfe_word_t win_q [WIN][WIN];
  logic      ws_vld_q;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ws_vld_q <= 1'b0;
      for (int r = 0; r < WIN; r++) begin
        for (int c = 0; c < WIN; c++) begin
          win_q[r][c] <= '0;
        end
      end
    end else if (i_ce) begin
      ws_vld_q <= s2_q.vld;
      if (s2_q.vld) begin
        for (int r = 0; r < WIN; r++) begin
          for (int c = 0; c < WIN - 1; c++) begin
            win_q[r][c] <= win_q[r][c+1];
          end
          win_q[r][WIN-1] <= tap[LB_ROWS-WIN+r]; // [R8] [R16]
        end
      end
    end
  end

  function automatic logic [9:0] adiff(input logic [9:0] a, input logic [9:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  bfe_col_t    ccol;
  logic [9:0]  cpix, navg, mx, mn, cfix, hav, vav, cav4, dav, dh, dv, gsel;
  logic [9:0]  nb [4];
  logic [11:0] nsum, dsum, csum, hsum, vsum;
  logic        defect, hz_e, vt_e;
  logic [9:0]  r_d, g_d, b_d;
  always_comb begin
    cpix  = win_q[2][2].pix;
    ccol  = bfe_col_t'({win_q[2][2].rp, win_q[2][2].cp} ^ i_cfg.bayer);
    nb[0] = win_q[0][2].pix;
    nb[1] = win_q[4][2].pix;
    nb[2] = win_q[2][0].pix;
    nb[3] = win_q[2][4].pix;
    nsum  = '0;
    mx    = '0;
    mn    = PIX_MAX;
    for (int i = 0; i < 4; i++) begin
      nsum = nsum + {2'b0, nb[i]};
      mx   = (nb[i] > mx) ? nb[i] : mx;
      mn   = (nb[i] < mn) ? nb[i] : mn;
    end
    navg   = nsum[11:2];
    // Hot or bright above all neighbours, or dark below all of them
    defect = i_cfg.dpc_en &&
             (({1'b0, cpix} > {1'b0, mx} + {1'b0, i_cfg.dpc_thr}) ||
              ({1'b0, cpix} + {1'b0, i_cfg.dpc_thr} < {1'b0, mn})); // [R9]
    cfix   = defect ? navg : cpix; // [R10]
    hsum   = {2'b0, win_q[2][1].pix} + {2'b0, win_q[2][3].pix};
    vsum   = {2'b0, win_q[1][2].pix} + {2'b0, win_q[3][2].pix};
    csum   = hsum + vsum;
    dsum   = {2'b0, win_q[1][1].pix} + {2'b0, win_q[1][3].pix} +
             {2'b0, win_q[3][1].pix} + {2'b0, win_q[3][3].pix};
    hav    = hsum[10:1];
    vav    = vsum[10:1];
    cav4   = csum[11:2];
    dav    = dsum[11:2];
    dh     = adiff(win_q[2][1].pix, win_q[2][3].pix);
    dv     = adiff(win_q[1][2].pix, win_q[3][2].pix);
    vt_e   = {1'b0, dh} + {1'b0, i_cfg.edge_thr} < {1'b0, dv}; // [R13]
    hz_e   = {1'b0, dv} + {1'b0, i_cfg.edge_thr} < {1'b0, dh}; // [R13]
    gsel   = vt_e ? hav : (hz_e ? vav : cav4); // [R14]
    case (ccol)
      BFE_R: begin
        r_d = cfix;
        g_d = gsel;
        b_d = dav;
      end
      BFE_B: begin
        r_d = dav;
        g_d = gsel;
        b_d = cfix;
      end
      BFE_GR: begin
        r_d = hav;
        g_d = cfix;
        b_d = vav;
      end
      default: begin
        r_d = vav;
        g_d = cfix;
        b_d = hav;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rgb <= '0;
    end else if (i_ce) begin
      o_rgb <= {ws_vld_q, win_q[2][2].sof, win_q[2][2].sol, r_d, g_d, b_d}; // [R12] [R15] [R16]
    end
  end

  property p_tp;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && i_cfg.tp_en && i_pix.vld |=> s0_q.pix == $past(tp_val);
  endproperty
  a_tp: assert property (p_tp) else $error("test pattern not substituted"); // [R3]

  property p_blk;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && s0_q.vld && s0_q.pix <= i_cfg.black |=> s1_q.pix == '0;
  endproperty
  a_blk: assert property (p_blk) else $error("black level underflow not clamped"); // [R4]

  property p_gain;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && s0_q.vld && i_cfg.gain == GAIN_ONE && s0_q.pix > i_cfg.black
    |=> s1_q.pix == $past(s0_q.pix) - $past(i_cfg.black);
  endproperty
  a_gain: assert property (p_gain) else $error("unity gain changed pixel"); // [R5]

  property p_sat;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && s0_q.vld && s0_q.pix == PIX_MAX && i_cfg.black == '0 && i_cfg.gain > GAIN_ONE
    |=> s1_q.pix == PIX_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("gain overflow not clamped"); // [R17]

  property p_shd;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && s1_q.vld && i_cfg.shd_k == '0 |=> s2_q.pix == $past(s1_q.pix);
  endproperty
  a_shd: assert property (p_shd) else $error("flat shading altered pixel"); // [R6]

  property p_dpc;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && ws_vld_q && defect && ccol == BFE_R |=> o_rgb.r == $past(navg);
  endproperty
  a_dpc: assert property (p_dpc) else $error("defect not replaced"); // [R10]

  property p_edge;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && ws_vld_q && !defect && ccol == BFE_R && vt_e
    |=> o_rgb.g == $past(hav) && o_rgb.r == $past(cpix);
  endproperty
  a_edge: assert property (p_edge) else $error("edge green not directional"); // [R13]

  property p_flat;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && ws_vld_q && ccol == BFE_B && !vt_e && !hz_e |=> o_rgb.g == $past(cav4);
  endproperty
  a_flat: assert property (p_flat) else $error("flat area not averaged"); // [R14]

  property p_align;
    @(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce |=> o_rgb.vld == $past(ws_vld_q) && o_rgb.sof == $past(win_q[2][2].sof);
  endproperty
  a_align: assert property (p_align) else $error("markers misaligned"); // [R16]

  c_defect: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && ws_vld_q && defect);
  c_tp: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && i_cfg.tp_en && i_pix.vld ##1 s0_q.vld);
  c_edge: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_ce && ws_vld_q && (vt_e || hz_e) ##1 o_rgb.vld);
endmodule

/* File: test/bfe_sensor_model.sv */
// Sensor readout model: W x H raw frames, back to back, split at column W/2.
// Assumes the core clock and clock enable of the pipeline.
`timescale 1ns/1ps
module bfe_sensor_model import bfe_pkg::*; #(
  parameter int W = 16,
  parameter int H = 10
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  input  wire logic       i_stall,
  input  wire logic [9:0] i_lo,
  input  wire logic [9:0] i_hi,
  input  wire logic       i_hot_en,
  output bfe_raw_t        o_pix
);
  int c;
  int r;
  always @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      c = 0;
      r = 0;
      o_pix <= '0;
    end else if (i_ce) begin
      if (o_pix.vld) begin
        c = (c == W - 1) ? 0 : c + 1;
        if (c == 0) r = (r == H - 1) ? 0 : r + 1;
      end
      o_pix.vld <= !i_stall;
      o_pix.sof <= !i_stall && c == 0 && r == 0;
      o_pix.sol <= !i_stall && c == 0;
      // Idle data toggles so stale values never look valid
      o_pix.data <= i_stall ? ~o_pix.data :
                    (i_hot_en && r == 6 && c == 6) ? 10'h3ff : (c < W / 2 ? i_lo : i_hi);
    end
  end
endmodule

/* File: test/bfe_pipe_tb.sv */
// Self-checking bench for bfe_pipe: flat, edge and hot pixel frames.
// Assumes the sensor model drives the raw stream.
`timescale 1ns/1ps
module bfe_pipe_tb;
  import bfe_pkg::*;
  localparam int W = 16;
  localparam int H = 10;
  logic        i_core_clk, i_arst_n, i_ce, stall, hot_en, armed;
  logic [9:0]  lo, hi, lv, er, eg, eb;
  logic [31:0] seed, rnd;
  bfe_raw_t    pix;
  bfe_cfg_t    cfg;
  bfe_rgb_t    o_rgb;
  int          failures, check_count, frames, orow, ocol, mode, cr, cc;

  bfe_sensor_model #(.W(W), .H(H)) bfe_sensor_model_i (.i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n), .i_ce(i_ce), .i_stall(stall), .i_lo(lo), .i_hi(hi),
    .i_hot_en(hot_en), .o_pix(pix));
  bfe_pipe bfe_pipe_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
    .i_pix(pix), .i_cfg(cfg), .o_rgb(o_rgb));

  initial begin
    i_core_clk = 0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [9:0] gexp(logic [9:0] l, logic [9:0] b, logic [7:0] g);
    int v;
    v = (l > b) ? ((int'(l) - int'(b)) * int'(g)) >>> 5 : 0;
    return (v > 1023) ? 10'h3ff : v[9:0];
  endfunction

  // Shading of a flat frame: x factor only, y at unity
  function automatic logic [9:0] shexp(logic [9:0] p, int k, int d);
    int v;
    v = (int'(p) * (int'(SHD_ONE) + ((d * d * k) >>> SHD_KSH))) >>> SHD_FRAC;
    return (v > 1023) ? 10'h3ff : v[9:0];
  endfunction

  task automatic close_out();
    $display("Checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Output position tracking; checks only in armed frames
  always @(posedge i_core_clk) begin
    if (i_arst_n && i_ce && o_rgb.vld === 1'b1) begin
      if (o_rgb.sof === 1'b1) begin
        if (armed) chk("frame rows", 33'(H - 1), 33'(orow));
        if (armed) chk("frame cols", 33'(W - 1), 33'(ocol));
        frames++;
        orow = 0;
        ocol = 0;
      end else if (o_rgb.sol === 1'b1) begin
        if (armed) chk("line cols", 33'(W - 1), 33'(ocol));
        orow++;
        ocol = 0;
      end else begin
        ocol++;
      end
      if (armed && (mode == 1 || (orow == cr && ocol == cc))) begin
        chk("red", 33'(er), 33'(o_rgb.r));
        chk("green", 33'(eg), 33'(o_rgb.g));
        chk("blue", 33'(eb), 33'(o_rgb.b));
      end
    end
  end

  always @(posedge i_core_clk) begin
    #1;
    rnd = $random(seed);
    i_ce = rnd[2:0] != 3'h0;
    stall = rnd[5:4] == 2'h0;
  end

  task automatic run(int m);
    int f0;
    f0 = frames;
    wait (frames == f0 + 2);
    @(posedge i_core_clk);
    #1;
    mode = m;
    armed = 1;
    wait (frames == f0 + 3);
    @(posedge i_core_clk);
    #1;
    armed = 0;
  endtask

  initial begin
    seed = 32'hde8fe34b;
    {failures, check_count, frames, orow, ocol, mode, cr, cc} = '0;
    {i_arst_n, stall, hot_en, armed, lo, hi} = '0;
    i_ce = 1;
    cfg = '0;
    cfg.gain = GAIN_ONE;
    cfg.edge_thr = 10'h10;
    cfg.dpc_thr = 10'h20;
    repeat (2) @(posedge i_core_clk);
    chk("reset rgb", 33'h0, o_rgb);
    #1;
    i_arst_n = 1;
    for (int i = 0; i < 10; i++) begin
      rnd = $random(seed);
      cfg.tp_en = rnd[31];
      cfg.black = (i == 0) ? 10'h3ff : ((i == 1) ? 10'h000 : {4'h0, rnd[5:0]});
      cfg.gain = (i == 1) ? 8'hff : rnd[13:6];
      lv = (i == 1) ? 10'h3ff : rnd[23:14];
      cfg.dpc_en = rnd[24];
      cfg.tp_level = cfg.tp_en ? lv : ~lv;
      lo = cfg.tp_en ? ~lv : lv;
      hi = lo;
      er = gexp(lv, cfg.black, cfg.gain);
      eg = er;
      eb = er;
      run(1);
    end
    {cfg.tp_en, cfg.black, cfg.dpc_en} = '0;
    cfg.gain = GAIN_ONE;
    lo = 10'h040;
    hi = 10'h300;
    cr = 4;
    cc = 8;
    {er, eg, eb} = {hi, hi, 10'h1a0};
    run(2);
    cfg.edge_thr = 10'h3ff;
    eg = 10'h250;
    run(2);
    cfg.edge_thr = 10'h10;
    // Ramps and checkerboard seen at row 4, column 8
    cfg.tp_en = 1;
    for (int t = 1; t < 4; t++) begin
      cfg.tp_sel = bfe_tp_t'(t);
      lv = (t == 1) ? 10'h008 : ((t == 2) ? 10'h004 : 10'h000);
      {er, eg, eb} = {lv, lv, lv};
      run(2);
    end
    cfg.tp_en = 0;
    cfg.tp_sel = TP_FLAT;
    // Far centre: every column 0..15 gives the same x factor
    cfg.ctr_x = 11'h7ff;
    for (int i = 0; i < 3; i++) begin
      cfg.shd_k[i][0][0] = 8'h01;
    end
    lo = 10'h300;
    hi = lo;
    er = shexp(lo, 1, 2047);
    eg = er;
    eb = er;
    run(1);
    cfg.shd_k = '0;
    cfg.ctr_x = '0;
    lo = 10'h155;
    hi = lo;
    hot_en = 1;
    cr = 6;
    cc = 6;
    cfg.dpc_en = 1;
    {er, eg, eb} = {lo, lo, lo};
    run(2);
    cfg.dpc_en = 0;
    er = 10'h3ff;
    run(2);
    close_out();
  end

  initial begin
    repeat (60000) @(posedge i_core_clk);
    failures++;
    $display("Error watchdog expected done seen timeout");
    close_out();
  end
endmodule
